// file: design/rfs_evt_if.sv
// event bundle from the fault sequencer to the register bank
// assumes one clock domain shared by both modules
`timescale 1ns/1ps

interface rfs_evt_if;
    import rfs_pkg::*;
    logic [2:0] live_pulse;
    logic [2:0] fault_set;
    modport seq (output live_pulse, output fault_set);
    modport bank (input live_pulse, input fault_set);
endinterface

// file: design/rfs_fault_seq.sv
// fault sequencer: one-cycle declare pulse, then fault state
// assumes synchronised comparator levels on the system clock
`timescale 1ns/1ps

module rfs_fault_seq (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       enable_i,
    input  wire logic [2:0] trip_i,
    rfs_evt_if.seq          evt
);
    import rfs_pkg::*;

    rfs_state_t state;
    rfs_state_t next_state;
    logic [2:0] held;
    logic [2:0] next_held;

    wire        any_trip = |trip_i;

    always_comb begin
        next_state = state;
        next_held  = held;
        case (state)
            RFS_RUN: begin
                if (enable_i && any_trip) begin
                    next_state = RFS_SHOW;
                    next_held  = trip_i;
                end
            end
            RFS_SHOW: begin
                next_state = RFS_FAULT;
            end
            RFS_FAULT: begin
                next_held = 3'h0;
                if (!enable_i) begin
                    next_state = RFS_RUN;
                end
            end
            default: begin
                next_state = RFS_RUN;
                next_held  = 3'h0;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= RFS_RUN;
            held  <= 3'h0;
        end else begin
            state <= next_state;
            held  <= next_held;
        end
    end

    assign evt.live_pulse = (state == RFS_SHOW) ? held : 3'h0;
    assign evt.fault_set  = (state == RFS_SHOW) ? held : 3'h0;
endmodule // rfs_fault_seq

// file: design/rfs_pkg.sv
// types of the regulator fault status block
// assumes rfs_regs.svh in the include path
`include "rfs_regs.svh"

package rfs_pkg;
    typedef logic [`RFS_ADDR_W-1:0] rfs_addr_t;
    typedef logic [`RFS_DATA_W-1:0] rfs_data_t;
    typedef logic [`RFS_NUM_FLAGS-1:0] rfs_flags_t;
    typedef enum logic [2:0] {
        RFS_RUN   = 3'b001,
        RFS_SHOW  = 3'b010,
        RFS_FAULT = 3'b100
    } rfs_state_t;
endpackage

// file: design/rfs_regs.svh
// register offsets, field positions and reset values of the fault registers
// assumes inclusion by the package and the design modules only
`ifndef RFS_REGS_SVH
`define RFS_REGS_SVH

`define RFS_ADDR_W          8
`define RFS_DATA_W          8
`define RFS_OFS_LATCHED     8'h01
`define RFS_OFS_LIVE        8'h02
`define RFS_OFS_MODE        8'h03
`define RFS_RST_LATCHED     8'h20
`define RFS_RST_LIVE        8'h18
`define RFS_RST_MODE        8'h00
`define RFS_BIT_POR         5
`define RFS_BIT_UVLOCK      4
`define RFS_BIT_OVERTEMP    3
`define RFS_BIT_OVERCUR     2
`define RFS_BIT_TIMEOUT     1
`define RFS_BIT_SHORT       0
`define RFS_BIT_MODE_EN     1
`define RFS_BIT_MODE_PWM    0
`define RFS_NUM_FLAGS       6

`endif

// file: design/rfs_top.sv
// regulator fault status registers with register read/write port
// assumes raw comparator levels from the analog side, one system clock
`timescale 1ns/1ps
`include "rfs_regs.svh"

module rfs_top (
    input  wire logic           SYS_CLK_I,
    input  wire logic           RST_I,
    input  wire rfs_pkg::rfs_addr_t REG_ADDR_I,
    input  wire rfs_pkg::rfs_data_t REG_WDATA_I,
    input  wire logic           REG_WR_I,
    input  wire logic           REG_RD_I,
    input  wire logic           UNDERVOLTAGE_LOCKOUT_I,
    input  wire logic           OVERTEMP_I,
    input  wire logic           OVERCUR_I,
    input  wire logic           TIMEOUT_I,
    input  wire logic           SHORT_I,
    output rfs_pkg::rfs_data_t  REG_RDATA_O,
    output logic                REG_RVALID_O,
    output logic                REGULATE_EN_O,
    output logic                FORCE_PWM_O,
    output logic                FAULT_STATE_O
);
    import rfs_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // input synchronisers: three stages, change taken when 2nd and 3rd agree
    localparam int NIN = 5;
    logic [NIN-1:0] raw;
    logic [NIN-1:0] s1;
    logic [NIN-1:0] s2;
    logic [NIN-1:0] s3;
    logic [NIN-1:0] cmp;

    assign raw = {UNDERVOLTAGE_LOCKOUT_I, OVERTEMP_I, OVERCUR_I,
                  TIMEOUT_I, SHORT_I};

    genvar g;
    generate
        for (g = 0; g < NIN; g++) begin : g_sync
            always_ff @(posedge SYS_CLK_I) begin
                if (RST_I) begin
                    s1[g]  <= 1'b0;
                    s2[g]  <= 1'b0;
                    s3[g]  <= 1'b0;
                    cmp[g] <= 1'b0;
                end else begin
                    s1[g] <= raw[g];
                    s2[g] <= s1[g];
                    s3[g] <= s2[g];
                    if (s2[g] == s3[g]) begin
                        cmp[g] <= s3[g];
                    end
                end
            end
        end
    endgenerate

    wire uvl_cmp = cmp[4];
    wire ot_cmp  = cmp[3];

    ////////////////////////////////////////////////////////////////////////
    // mode register
    rfs_data_t mode;
    wire       hit_latched = (REG_ADDR_I == `RFS_OFS_LATCHED);
    wire       hit_live    = (REG_ADDR_I == `RFS_OFS_LIVE);
    wire       hit_mode    = (REG_ADDR_I == `RFS_OFS_MODE);
    wire       wr_mode     = REG_WR_I && hit_mode;
    wire       rd_latched  = REG_RD_I && hit_latched;
    wire       enable      = mode[`RFS_BIT_MODE_EN];

    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            mode <= `RFS_RST_MODE;
        end else if (wr_mode) begin
            mode <= {6'h00, REG_WDATA_I[1:0]};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // fault sequencer
    rfs_evt_if evt ();

    rfs_fault_seq u_seq (
        .clk_i    (SYS_CLK_I),
        .rst_i    (RST_I),
        .enable_i (enable),
        .trip_i   (cmp[2:0]),
        .evt      (evt.seq)
    );

    ////////////////////////////////////////////////////////////////////////
    // latched fault flags
    rfs_flags_t latched;
    rfs_flags_t set_vec;
    rfs_flags_t next_latched;
    logic       uvl_q;
    logic       ot_q;

    wire uvl_evt = enable && uvl_cmp && !uvl_q;
    wire ot_evt  = enable && ot_cmp && !ot_q;

    assign set_vec = {1'b0, uvl_evt, ot_evt, evt.fault_set};

    // clear on read, set wins over clear
    assign next_latched = (rd_latched ? '0 : latched) | set_vec;

    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            uvl_q <= 1'b0;
            ot_q  <= 1'b0;
        end else begin
            uvl_q <= uvl_cmp;
            ot_q  <= ot_cmp;
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            latched <= rfs_flags_t'(`RFS_RST_LATCHED);
        end else begin
            latched <= next_latched;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // live status
    rfs_data_t live;
    assign live = {3'h0,
                   enable ? uvl_cmp : 1'b1,
                   enable ? ot_cmp  : 1'b1,
                   evt.live_pulse};

    ////////////////////////////////////////////////////////////////////////
    // read port
    // unused bits and addresses read zero
    wire rfs_data_t rd_mux = hit_latched ? {2'h0, latched} :
                             hit_live    ? live :
                             hit_mode    ? mode : 8'h00;

    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            REG_RDATA_O   <= 8'h00;
            REG_RVALID_O  <= 1'b0;
            REGULATE_EN_O <= 1'b0;
            FORCE_PWM_O   <= 1'b0;
            FAULT_STATE_O <= 1'b0;
        end else begin
            REG_RVALID_O  <= REG_RD_I;
            if (REG_RD_I) begin
                REG_RDATA_O <= rd_mux;
            end
            REGULATE_EN_O <= enable;
            FORCE_PWM_O   <= mode[`RFS_BIT_MODE_PWM];
            FAULT_STATE_O <= FAULT_STATE_O ? enable : |evt.fault_set;
        end
    end
endmodule // rfs_top

// file: dv/regulator_fault_status_regs_tb.sv
// self-checking bench for the fault status registers
// assumes rfs_host as the register master
`timescale 1ns/1ps

module regulator_fault_status_regs_tb;
    import rfs_pkg::*;
    logic      clk, rst, wr, rd, rvalid, en, pwm, fst;
    rfs_addr_t addr;
    rfs_data_t wdata, rdata, d;
    logic [4:0] pins;
    int        failures, tests_run, hits;
    rfs_top i_dut (.SYS_CLK_I(clk), .RST_I(rst), .REG_ADDR_I(addr),
        .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd),
        .UNDERVOLTAGE_LOCKOUT_I(pins[4]), .OVERTEMP_I(pins[3]),
        .OVERCUR_I(pins[2]), .TIMEOUT_I(pins[1]), .SHORT_I(pins[0]),
        .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid), .REGULATE_EN_O(en),
        .FORCE_PWM_O(pwm), .FAULT_STATE_O(fst));
    rfs_host i_host (.clk_i(clk), .rdata_i(rdata), .addr_o(addr),
        .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
    task automatic chk(input string n, input rfs_data_t e, rfs_data_t g);
        tests_run++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rdchk(input string n, input rfs_addr_t a, rfs_data_t e);
        i_host.rd_reg(a, d);
        chk(n, e, d);
    endtask
    task automatic results;
        $display("tests_run %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        rst = 1'b1;
        pins = 5'h00;
        repeat (4) @(negedge clk);
        rst = 1'b0;
        rdchk("por_flag", 8'h01, 8'h20);
        rdchk("read_clear", 8'h01, 8'h00);
        rdchk("live_disabled", 8'h02, 8'h18);
        rdchk("unmapped", 8'h05, 8'h00);
        i_host.wr_reg(8'h01, 8'hff);
        i_host.wr_reg(8'h02, 8'hff);
        rdchk("write_ignored", 8'h01, 8'h00);
        $display("test reset_access done");
        i_host.wr_reg(8'h03, 8'h02);
        rdchk("mode", 8'h03, 8'h02);
        chk("regulate_en", 8'h01, {7'h00, en});
        chk("force_pwm_off", 8'h00, {7'h00, pwm});
        i_host.wr_reg(8'h03, 8'h03);
        rdchk("mode_pwm", 8'h03, 8'h03);
        chk("force_pwm_on", 8'h01, {7'h00, pwm});
        rdchk("live_enabled", 8'h02, 8'h00);
        pins = 5'h18;
        repeat (8) @(negedge clk);
        rdchk("live_trip", 8'h02, 8'h18);
        rdchk("latch_uv_ot", 8'h01, 8'h18);
        pins = 5'h00;
        $display("test comparators done");
        for (int k = 0; k < 3; k++) begin
            pins = 5'h04 >> k;
            i_host.poll(2 - k, hits);
            chk("pulse_count", 8'h01, 8'(hits));
            chk("fault_state", 8'h01, {7'h00, fst});
            rdchk("latch_event", 8'h01, 8'h04 >> k);
            pins = 5'h00;
            i_host.wr_reg(8'h03, 8'h00);
            i_host.wr_reg(8'h03, 8'h02);
            repeat (8) @(negedge clk);
        end
        $display("test fault_events done");
        results();
    end
endmodule // regulator_fault_status_regs_tb

// file: dv/rfs_host.sv
// host model driving the register read/write strobes
// assumes strobes sampled on the rising clock edge
`timescale 1ns/1ps

module rfs_host (
    input  wire logic      clk_i,
    input  rfs_pkg::rfs_data_t rdata_i,
    output rfs_pkg::rfs_addr_t addr_o,
    output rfs_pkg::rfs_data_t wdata_o,
    output logic           wr_o,
    output logic           rd_o
);
    import rfs_pkg::*;
    initial begin
        addr_o = 8'h00;
        wdata_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end
    task automatic wr_reg(input rfs_addr_t a, input rfs_data_t d);
        @(negedge clk_i);
        addr_o = a;
        wdata_o = d;
        wr_o = 1'b1;
        @(negedge clk_i);
        wr_o = 1'b0;
        addr_o = ~a;
        wdata_o = ~d;
    endtask
    task automatic rd_reg(input rfs_addr_t a, output rfs_data_t d);
        @(negedge clk_i);
        addr_o = a;
        rd_o = 1'b1;
        @(negedge clk_i);
        rd_o = 1'b0;
        addr_o = ~a;
        d = rdata_i;
    endtask
    // back-to-back live reads, counting cycles with bit b set
    task automatic poll(input int b, output int hits);
        hits = 0;
        @(negedge clk_i);
        addr_o = 8'h02;
        rd_o = 1'b1;
        repeat (12) begin
            @(negedge clk_i);
            hits += (rdata_i[b] === 1'b1);
        end
        rd_o = 1'b0;
    endtask
endmodule // rfs_host

// file: dv/rfs_top_sva.sv
// assertions on the register port of the fault status block
// assumes one system clock and synchronous active-high reset
`timescale 1ns/1ps

module rfs_top_sva (
    input wire logic               SYS_CLK_I,
    input wire logic               RST_I,
    input wire rfs_pkg::rfs_addr_t REG_ADDR_I,
    input wire rfs_pkg::rfs_data_t REG_WDATA_I,
    input wire logic               REG_WR_I,
    input wire logic               REG_RD_I,
    input wire rfs_pkg::rfs_data_t REG_RDATA_O,
    input wire logic               REG_RVALID_O,
    input wire logic               REGULATE_EN_O,
    input wire logic               FAULT_STATE_O
);
    import rfs_pkg::*;
    wire rd1 = REG_RD_I && REG_ADDR_I == 8'h01;
    wire rd2 = REG_RD_I && REG_ADDR_I == 8'h02;
    wire rdx = REG_RD_I && (REG_ADDR_I == 8'h00 || REG_ADDR_I > 8'h03);
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (RST_I);
    sequence mode_wr;
        REG_WR_I && REG_ADDR_I == 8'h03;
    endsequence
    sequence mode_rd;
        REG_RD_I && !REG_WR_I && REG_ADDR_I == 8'h03;
    endsequence
    ////////////////////////////////////////
    rvalid_pulse_a: assert property (
        REG_RVALID_O == $past(REG_RD_I)) else $error("rvalid timing");
    rdata_hold_a: assert property (
        !REG_RD_I |=> $stable(REG_RDATA_O)) else $error("rdata moved");
    unmapped_zero_a: assert property (
        rdx |=> REG_RDATA_O == 8'h00) else $error("unmapped not 0");
    latched_unused_a: assert property (
        rd1 |=> REG_RDATA_O[7:6] == 2'b00) else $error("latched unused");
    live_unused_a: assert property (
        rd2 |=> REG_RDATA_O[7:5] == 3'b000) else $error("live unused");
    fault_live_a: assert property (
        FAULT_STATE_O && rd2 |=> REG_RDATA_O[2:0] == 3'b000)
        else $error("live bit in fault");
    fault_cause_a: assert property (
        $rose(FAULT_STATE_O) |-> REGULATE_EN_O) else $error("fault off");
    mode_back_a: assert property (
        mode_wr ##2 mode_rd |=>
        REG_RDATA_O == {6'h00, $past(REG_WDATA_I[1:0], 3)})
        else $error("mode readback");
    enable_follow_a: assert property (
        mode_wr |=> ##1 REGULATE_EN_O == $past(REG_WDATA_I[1], 2))
        else $error("enable lag");
endmodule // rfs_top_sva

bind rfs_top rfs_top_sva i_sva (.SYS_CLK_I(SYS_CLK_I), .RST_I(RST_I),
    .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I),
    .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O),
    .REG_RVALID_O(REG_RVALID_O), .REGULATE_EN_O(REGULATE_EN_O),
    .FAULT_STATE_O(FAULT_STATE_O));
